/* File: hw/fpe_top.sv */
// fpe_top: frequency source selection, six frequency elements, four rate elements
// assumes: APB master on clk, front end measurements synchronous to clk
//
// Design decisions made here: the APB register port and the register offsets.
`timescale 1ns/100ps
`default_nettype none
// Overview of operation
// - with voltage option, v1 above 10 V for three cycles selects v1 frequency
// - otherwise i1 frequency is used when i1 reaches a tenth of ct rating
// - with neither signal adequate, measured frequency equals nominal frequency
// - six frequency elements, each with level (off or 20-70 Hz) and delay
// - level below nominal acts as underfrequency, picks up below level
// - level above nominal acts as overfrequency, picks up above level
// - trip flag asserts after pickup persists for its delay, 0-655.35 s
// - four rate elements, enable count off or 1-4 selects active ones
// - rate taken from two frequency samples spaced by level-chosen window
// - window 3 cycles for fastest band, plus 3 per band, 30 at bottom
// - rate pickup at 100 percent of level, dropout below 95 percent
// - rising or falling trend restricts operation to that direction
// - rising or falling trend also compares frequency against nominal
// - absolute trend uses rate magnitude in either direction
// - rate elements need v1 and i1 above supervision levels, off skips
// - rate elements blocked unless tracking valid flag is set
// - rate trip flag qualified by pickup delay and dropout delay
module fpe_top
	import fpe_pkg::*;
#(
	parameter int N_FREQ     = 6,
	parameter int N_RATE     = 4,
	parameter int STEP_CYC   = TIMER_STEP_CYC
) (
	// clock and reset
	input  wire logic              clk,
	input  wire logic              rst_n,
	// apb slave
	input  wire logic              psel,
	input  wire logic              penable,
	input  wire logic              pwrite,
	input  wire logic [7:0]        paddr,
	input  wire logic [31:0]       pwdata,
	output var  logic [31:0]       prdata,
	output var  logic              pready,
	output var  logic              pslverr,
	// front end measurements
	input  wire fpe_meas_t         meas,
	// element outputs
	output var  logic [N_FREQ-1:0] freq_trip_flag,
	output var  logic [N_RATE-1:0] rate_trip_flag,
	output var  logic [15:0]       measured_freq,
	output var  fpe_src_t          freq_source
);
	initial begin
		if (N_FREQ != 6 || N_RATE != 4 || STEP_CYC < 1)
			$error("fpe_top: unsupported parameter values");
	end

	// ----------------------------------------------------------------
	// configuration registers
	// ----------------------------------------------------------------
	logic [15:0]   nominal_frequency;
	logic          voltage_option;
	logic [2:0]    rate_enable_count;
	logic [15:0]   rate_voltage_supervision;
	logic [15:0]   rate_current_supervision;
	logic [15:0]   nominal_ct_current;
	logic [15:0]   freq_level        [N_FREQ];
	logic [15:0]   freq_pickup_delay [N_FREQ];
	fpe_rate_cfg_t rate_cfg          [N_RATE];

	// ----------------------------------------------------------------
	// apb access: one wait cycle, answer registered
	// ----------------------------------------------------------------
	logic        acc;
	logic        wr_en;
	logic [31:0] next_rdata;
	logic        next_err;
	logic [2:0]  fidx;
	logic [1:0]  ridx;
	logic        f_hit;
	logic        r_hit;

	assign acc   = psel && penable && !pready;
	assign wr_en = psel && penable && pready && pwrite && !pslverr;
	assign fidx  = 3'((paddr - REG_FREQ_BASE) >> 2);
	assign ridx  = 2'((paddr - REG_RATE_BASE) >> 3);
	assign f_hit = paddr >= REG_FREQ_BASE && paddr < REG_RATE_BASE
		&& paddr[1:0] == 2'h0 && fidx < 3'(N_FREQ);
	assign r_hit = paddr >= REG_RATE_BASE && paddr < REG_STATUS && paddr[1:0] == 2'h0;

	// read mux and decode
	always_comb begin
		next_rdata = 32'h0000_0000;
		next_err   = 1'b0;
		if (f_hit) begin
			next_rdata = {freq_pickup_delay[fidx], freq_level[fidx]};
		end else if (r_hit && !paddr[2]) begin
			next_rdata = {14'h0000, rate_cfg[ridx].trend, rate_cfg[ridx].rate_level};
		end else if (r_hit) begin
			next_rdata = {rate_cfg[ridx].dropout_delay, rate_cfg[ridx].pickup_delay};
		end else begin
			case (paddr)
				REG_CONFIG: next_rdata = {12'h000, rate_enable_count, voltage_option,
					nominal_frequency};
				REG_SUPERV: next_rdata = {rate_current_supervision, rate_voltage_supervision};
				REG_CT_NOM: next_rdata = {16'h0000, nominal_ct_current};
				REG_STATUS: next_rdata = {measured_freq, 4'h0, freq_source,
					rate_trip_flag, freq_trip_flag};
				default:    next_err = 1'b1;
			endcase
		end
	end

	// handshake and answer
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			pready  <= 1'b0;
			prdata  <= 32'h0000_0000;
			pslverr <= 1'b0;
		end else begin
			pready  <= acc;
			prdata  <= acc && !pwrite ? next_rdata : 32'h0000_0000;
			pslverr <= acc && (next_err || (pwrite && paddr == REG_STATUS));
		end
	end

	// register writes at the completing edge
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			nominal_frequency        <= NOM_FREQ_RST;
			voltage_option           <= 1'b1;
			rate_enable_count        <= 3'h0;
			rate_voltage_supervision <= VSUP_RST;
			rate_current_supervision <= 16'h0000;
			nominal_ct_current       <= CT_NOM_RST;
			for (int k = 0; k < N_FREQ; k++) begin
				freq_level[k]        <= 16'h0000;
				freq_pickup_delay[k] <= FREQ_DLY_RST;
			end
			for (int k = 0; k < N_RATE; k++) begin
				rate_cfg[k] <= '{16'h0000, TREND_ABSOLUTE, RATE_DLY_RST, 16'h0000};
			end
		end else if (wr_en) begin
			if (f_hit) begin
				// levels outside 20-70 Hz other than off are refused
				if (pwdata[15:0] == 16'h0000 || (pwdata[15:0] >= FREQ_LEVEL_LO
					&& pwdata[15:0] <= FREQ_LEVEL_HI))
					freq_level[fidx] <= pwdata[15:0];
				freq_pickup_delay[fidx] <= pwdata[31:16];
			end else if (r_hit && !paddr[2]) begin
				rate_cfg[ridx].rate_level <= pwdata[15:0];
				if (pwdata[17:16] != 2'h3)
					rate_cfg[ridx].trend <= fpe_trend_t'(pwdata[17:16]);
			end else if (r_hit) begin
				rate_cfg[ridx].pickup_delay  <= pwdata[15:0];
				rate_cfg[ridx].dropout_delay <= pwdata[31:16];
			end else begin
				case (paddr)
					REG_CONFIG: begin
						nominal_frequency <= pwdata[15:0];
						voltage_option    <= pwdata[16];
						if (pwdata[19:17] <= 3'(N_RATE))
							rate_enable_count <= pwdata[19:17];
					end
					REG_SUPERV: begin
						rate_voltage_supervision <= pwdata[15:0];
						rate_current_supervision <= pwdata[31:16];
					end
					REG_CT_NOM: nominal_ct_current <= pwdata[15:0];
					default: ;
				endcase
			end
		end
	end

	// ----------------------------------------------------------------
	// 10 ms step for delay timers
	// ----------------------------------------------------------------
	logic [31:0] step_cnt;
	logic        step;

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			step_cnt <= 32'h0000_0000;
			step     <= 1'b0;
		end else begin
			step     <= step_cnt == 32'(STEP_CYC - 1);
			step_cnt <= step_cnt == 32'(STEP_CYC - 1) ? 32'h0000_0000 : step_cnt + 32'h1;
		end
	end

	// ----------------------------------------------------------------
	// frequency source selection, once per power cycle
	// ----------------------------------------------------------------
	logic [1:0] volt_good_cnt;
	logic       volt_ok;
	logic       cur_ok;

	assign volt_ok = voltage_option && meas.v1_mag > VOLT_SRC_MIN
		&& volt_good_cnt >= 2'(VOLT_QUAL_CYC - 1);
	assign cur_ok  = 20'(meas.i1_mag) * 20'(CUR_SRC_DIV) >= 20'(nominal_ct_current);

	// count consecutive cycles of adequate v1
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			volt_good_cnt <= 2'h0;
		end else if (meas.cycle_strobe) begin
			if (meas.v1_mag <= VOLT_SRC_MIN)
				volt_good_cnt <= 2'h0;
			else if (volt_good_cnt != 2'(VOLT_QUAL_CYC))
				volt_good_cnt <= volt_good_cnt + 2'h1;
		end
	end

	// pick the frequency in priority voltage, current, nominal
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			measured_freq <= NOM_FREQ_RST;
			freq_source   <= SRC_NOMINAL;
		end else if (meas.cycle_strobe) begin
			if (volt_ok) begin
				measured_freq <= meas.freq_v;
				freq_source   <= SRC_VOLTAGE;
			end else if (cur_ok) begin
				measured_freq <= meas.freq_i;
				freq_source   <= SRC_CURRENT;
			end else begin
				measured_freq <= nominal_frequency;
				freq_source   <= SRC_NOMINAL;
			end
		end
	end

	// ----------------------------------------------------------------
	// over / under frequency elements
	// ----------------------------------------------------------------
	logic [N_FREQ-1:0] freq_pick;

	for (genvar g = 0; g < N_FREQ; g++) begin : g_freq
		logic tq;
		// direction follows the level against nominal
		always_ff @(posedge clk) begin
			if (!rst_n || freq_level[g] == 16'h0000) begin
				freq_pick[g] <= 1'b0;
			end else if (freq_level[g] < nominal_frequency) begin
				freq_pick[g] <= measured_freq < freq_level[g];
			end else begin
				freq_pick[g] <= freq_level[g] > nominal_frequency
					&& measured_freq > freq_level[g];
			end
		end
		fpe_timer #(.W(16)) u_tmr (
			.clk           (clk),
			.rst_n         (rst_n),
			.step          (step),
			.cond          (freq_pick[g]),
			.pickup_delay  (freq_pickup_delay[g]),
			.dropout_delay (16'h0000),
			.q             (tq)
		);
		always_ff @(posedge clk) begin
			if (!rst_n)
				freq_trip_flag[g] <= 1'b0;
			else
				freq_trip_flag[g] <= tq && freq_pick[g];
		end
	end

	// ----------------------------------------------------------------
	// frequency history, newest at index 0
	// ----------------------------------------------------------------
	logic [15:0] hist [HIST_DEPTH];

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			for (int k = 0; k < HIST_DEPTH; k++)
				hist[k] <= NOM_FREQ_RST;
		end else if (meas.cycle_strobe) begin
			hist[0] <= volt_ok ? meas.freq_v : (cur_ok ? meas.freq_i : nominal_frequency);
			for (int k = 1; k < HIST_DEPTH; k++)
				hist[k] <= hist[k-1];
		end
	end

	// window in power cycles for a rate level
	function automatic logic [4:0] rate_window(input logic [15:0] level);
		logic [4:0] w;
		w = 5'(WIN_STEP * (WIN_BANDS + 1));
		for (int b = WIN_BANDS - 1; b >= 0; b--)
			if (level >= WIN_EDGE[b])
				w = 5'(WIN_STEP * (b + 1));
		return w;
	endfunction

	// ----------------------------------------------------------------
	// rate-of-change elements
	// ----------------------------------------------------------------
	logic supv_ok;

	assign supv_ok = meas.tracking_valid
		&& (rate_voltage_supervision == 16'h0000
			|| meas.v1_mag > rate_voltage_supervision)
		&& (rate_current_supervision == 16'h0000
			|| meas.i1_mag > rate_current_supervision);

	for (genvar g = 0; g < N_RATE; g++) begin : g_rate
		logic [4:0]  rate_win;
		logic [15:0] first_freq_sample;
		logic [15:0] second_freq_sample;
		logic [15:0] mag;
		logic        rising;
		logic        dir_ok;
		logic [47:0] lhs;
		logic [47:0] base;
		logic        over_pu;
		logic        under_do;
		logic        active;
		logic        pick;
		logic        tq;

		assign rate_win           = rate_window(rate_cfg[g].rate_level);
		assign second_freq_sample = hist[0];
		assign first_freq_sample  = hist[rate_win];
		assign rising             = second_freq_sample > first_freq_sample;
		assign mag = rising ? second_freq_sample - first_freq_sample
			: first_freq_sample - second_freq_sample;
		// rate = mag * nominal / (scale * window), compared by cross-multiplying
		assign lhs  = 48'(mag) * 48'(nominal_frequency) * 48'(RATE_SCALE);
		assign base = 48'(rate_cfg[g].rate_level) * 48'(rate_win) * 48'(RATE_SCALE);
		assign over_pu  = lhs >= base * 48'(RATE_PU_PCT);
		assign under_do = lhs <  base * 48'(RATE_DO_PCT);

		// direction and nominal supervision per trend
		always_comb begin
			case (rate_cfg[g].trend)
				TREND_RISING:  dir_ok = rising
					&& second_freq_sample > nominal_frequency;
				TREND_FALLING: dir_ok = !rising && mag != 16'h0000
					&& second_freq_sample < nominal_frequency;
				default:       dir_ok = 1'b1;
			endcase
		end

		assign active = rate_cfg[g].rate_level != 16'h0000
			&& 3'(g) < rate_enable_count && supv_ok;

		// pickup with hysteresis, re-evaluated each power cycle
		always_ff @(posedge clk) begin
			if (!rst_n || !active) begin
				pick <= 1'b0;
			end else if (meas.cycle_strobe) begin
				if (!pick)
					pick <= over_pu && dir_ok;
				else
					pick <= !under_do && dir_ok;
			end
		end

		fpe_timer #(.W(16)) u_tmr (
			.clk           (clk),
			.rst_n         (rst_n),
			.step          (step),
			.cond          (pick),
			.pickup_delay  (rate_cfg[g].pickup_delay),
			.dropout_delay (rate_cfg[g].dropout_delay),
			.q             (tq)
		);
		always_ff @(posedge clk) begin
			if (!rst_n)
				rate_trip_flag[g] <= 1'b0;
			else
				rate_trip_flag[g] <= tq && active;
		end
	end
endmodule
`default_nettype wire

/* File: hw/fpe_pkg.sv */
// fpe_pkg: constants, register map and carrier types of the frequency protection block
// assumes: 40 MHz system clock, front end values in fixed-point units noted below
package fpe_pkg;

	// ----------------------------------------------------------------
	// timing
	// ----------------------------------------------------------------
	localparam int CLK_PERIOD_NS  = 25;            // 40 MHz
	localparam int TIMER_STEP_NS  = 10_000_000;    // delay settings count 10 ms steps
	localparam int TIMER_STEP_CYC = TIMER_STEP_NS / CLK_PERIOD_NS;
	localparam int VOLT_QUAL_CYC  = 3;             // power cycles of good voltage
	localparam int HIST_DEPTH     = 31;            // longest window plus current sample

	// ----------------------------------------------------------------
	// measurement thresholds (freq 0.01 Hz, volts 0.01 V, amps 0.01 A)
	// ----------------------------------------------------------------
	localparam logic [15:0] VOLT_SRC_MIN  = 16'h03E8; // 10.00 V secondary
	localparam int          CUR_SRC_DIV   = 10;       // one tenth of ct rating
	localparam logic [15:0] FREQ_LEVEL_LO = 16'h07D0; // 20.00 Hz
	localparam logic [15:0] FREQ_LEVEL_HI = 16'h1B58; // 70.00 Hz
	localparam int          RATE_SCALE    = 100;      // 0.01 unit scaling
	localparam int          RATE_PU_PCT   = 100;
	localparam int          RATE_DO_PCT   = 95;
	localparam int          WIN_STEP      = 3;        // window grows in 3 cycle bands
	localparam int          WIN_BANDS     = 9;
	// lower edge of each rate band, 0.01 Hz/s, fastest band first
	localparam logic [15:0] WIN_EDGE [WIN_BANDS] = '{
		16'h00E9, 16'h0075, 16'h004E, 16'h003A, 16'h002F,
		16'h0026, 16'h0021, 16'h001D, 16'h001A};

	// ----------------------------------------------------------------
	// register map (byte addresses)
	// ----------------------------------------------------------------
	localparam logic [7:0] REG_CONFIG    = 8'h00;
	localparam logic [7:0] REG_SUPERV    = 8'h04;
	localparam logic [7:0] REG_CT_NOM    = 8'h08;
	localparam logic [7:0] REG_FREQ_BASE = 8'h10; // six words, step 4
	localparam logic [7:0] REG_RATE_BASE = 8'h30; // four pairs, step 8
	localparam logic [7:0] REG_STATUS    = 8'h50;

	// reset values
	localparam logic [15:0] NOM_FREQ_RST  = 16'h1770; // 60.00 Hz
	localparam logic [15:0] FREQ_DLY_RST  = 16'h0064; // 1.00 s
	localparam logic [15:0] RATE_DLY_RST  = 16'h0064; // 1.00 s
	localparam logic [15:0] CT_NOM_RST    = 16'h01F4; // 5.00 A
	localparam logic [15:0] VSUP_RST      = 16'h0000;

	// ----------------------------------------------------------------
	// types
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {TREND_RISING, TREND_FALLING, TREND_ABSOLUTE} fpe_trend_t;
	typedef enum logic [1:0] {SRC_NOMINAL, SRC_VOLTAGE, SRC_CURRENT} fpe_src_t;

	typedef struct packed {
		logic [15:0] freq_v;         // frequency tracked on v1
		logic [15:0] freq_i;         // frequency tracked on i1
		logic [15:0] v1_mag;         // positive-sequence volts
		logic [15:0] i1_mag;         // positive-sequence amps
		logic        tracking_valid; // relay tracks system frequency
		logic        cycle_strobe;   // one pulse per power-system cycle
	} fpe_meas_t;

	typedef struct packed {
		logic [15:0] rate_level;
		fpe_trend_t  trend;
		logic [15:0] pickup_delay;
		logic [15:0] dropout_delay;
	} fpe_rate_cfg_t;

endpackage

/* File: hw/fpe_timer.sv */
// fpe_timer: pickup / dropout qualifying timer in 10 ms steps
// assumes: step is a one-cycle pulse from the parent
`timescale 1ns/100ps
`default_nettype none
module fpe_timer #(
	parameter int W = 16
) (
	// clock and reset
	input  wire logic         clk,
	input  wire logic         rst_n,
	// timing
	input  wire logic         step,
	input  wire logic         cond,
	input  wire logic [W-1:0] pickup_delay,
	input  wire logic [W-1:0] dropout_delay,
	// result
	output var  logic         q
);
	initial begin
		if (W < 2) $error("fpe_timer width too small");
	end

	logic [W-1:0] count;

	// qualify changes of cond; restart whenever cond returns early
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			count <= '0;
			q     <= 1'b0;
		end else if (cond == q) begin
			count <= '0;
		end else if (count >= (cond ? pickup_delay : dropout_delay)) begin
			q     <= cond;
			count <= '0;
		end else if (step) begin
			count <= count + 1'b1;
		end
	end
endmodule
`default_nettype wire

/* File: bench/fpe_chk.sv */
// fpe_chk: port-level assertions on fpe_top
// assumes: one clock domain, bound into every fpe_top instance
`timescale 1ns/100ps
`default_nettype none
module fpe_chk
	import fpe_pkg::*;
#(
	parameter int N_RATE = 4
) (
	// clock and reset
	input  wire logic              clk,
	input  wire logic              rst_n,
	// apb
	input  wire logic              psel,
	input  wire logic              penable,
	input  wire logic [31:0]       prdata,
	input  wire logic              pready,
	input  wire logic              pslverr,
	// measurement and results
	input  wire fpe_meas_t         meas,
	input  wire logic [N_RATE-1:0] rate_trip_flag,
	input  wire logic [15:0]       measured_freq,
	input  wire fpe_src_t          freq_source
);
	logic [1:0] v_good;

	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);

	// consecutive strobes with v1 above the minimum, saturating at 3
	always_ff @(posedge clk) begin
		if (!rst_n || (meas.cycle_strobe && meas.v1_mag <= VOLT_SRC_MIN)) begin
			v_good <= 2'h0;
		end else if (meas.cycle_strobe && v_good != 2'h3) begin
			v_good <= v_good + 2'h1;
		end
	end

	// a strobe and the edges that carry its result
	sequence taken_s;
		meas.cycle_strobe ##2 1'b1;
	endsequence

	// apb answer
	pready_time_a: assert property (psel && penable && !pready |=> pready)
		else $error("pready missing after access");
	pready_pulse_a: assert property (pready |=> !pready)
		else $error("pready longer than one cycle");
	pslverr_ready_a: assert property (pslverr |-> pready)
		else $error("pslverr without pready");
	prdata_idle_a: assert property (!pready |-> prdata == 32'h0)
		else $error("read data outside answer");
	// frequency source, measurement and rate blocking without tracking
	vsrc_follow_a: assert property (taken_s ##0 freq_source == SRC_VOLTAGE
		|-> measured_freq == $past(meas.freq_v))
		else $error("frequency not from voltage channel");
	vsrc_qual_a: assert property ($rose(freq_source == SRC_VOLTAGE) |-> v_good == 2'h3)
		else $error("voltage source chosen too early");
	isrc_follow_a: assert property (taken_s ##0 freq_source == SRC_CURRENT
		|-> measured_freq == $past(meas.freq_i))
		else $error("frequency not from current channel");
	freq_hold_a: assert property ($changed(measured_freq)
		|-> $past(meas.cycle_strobe) || $past(meas.cycle_strobe, 2))
		else $error("frequency changed between strobes");
	rate_track_a: assert property (!meas.tracking_valid [*3] |-> rate_trip_flag == '0)
		else $error("rate trip without tracking");
endmodule

bind fpe_top fpe_chk #(.N_RATE(N_RATE)) u_chk (
	.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable), .prdata(prdata),
	.pready(pready), .pslverr(pslverr), .meas(meas), .rate_trip_flag(rate_trip_flag),
	.measured_freq(measured_freq), .freq_source(freq_source));
`default_nettype wire

/* File: bench/fpe_fe_model.sv */
// fpe_fe_model: front end giving one strobe per power cycle
// assumes: bench sets the quantities; they are taken at each strobe
`timescale 1ns/100ps
`default_nettype none
module fpe_fe_model
	import fpe_pkg::*;
#(
	parameter int PERIOD = 8
) (
	// clock and reset
	input  wire logic        clk,
	input  wire logic        rst_n,
	// quantities wanted by the bench
	input  wire logic [15:0] fv,
	input  wire logic [15:0] fi,
	input  wire logic [15:0] v1,
	input  wire logic [15:0] i1,
	input  wire logic        trk,
	// measurement bus
	output var  fpe_meas_t   meas
);
	int cnt;

	// power cycle counter
	always_ff @(posedge clk) begin
		if (!rst_n || cnt == PERIOD - 1) begin
			cnt <= 0;
		end else begin
			cnt <= cnt + 1;
		end
	end

	// values refreshed with the strobe and held for the whole cycle
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			meas <= '0;
		end else if (cnt == PERIOD - 1) begin
			meas <= '{fv, fi, v1, i1, trk, 1'b1};
		end else begin
			meas.cycle_strobe <= 1'b0;
		end
	end
endmodule
`default_nettype wire

/* File: bench/testbench.sv */
// testbench: self-checking bench for fpe_top
// assumes: package, design, front end model and checker compiled before
`timescale 1ns/100ps
`default_nettype none
module testbench
	import fpe_pkg::*;
;
	logic        clk = 1'b0;
	logic        rst_n = 1'b0;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic [7:0]  paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [15:0] fv = 16'h177A;
	logic [15:0] fi = 16'h1766;
	logic [15:0] v1 = 16'h0000;
	logic [15:0] i1 = 16'h0000;
	logic        trk = 1'b1;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	fpe_meas_t   meas;
	logic [5:0]  ftrip;
	logic [3:0]  rtrip;
	logic [15:0] mfreq;
	fpe_src_t    src;
	int          failures = 0;
	int          n_checks = 0;

	// 40 MHz clock
	always #12.5 clk = ~clk;

	fpe_top #(.STEP_CYC(4)) dut (.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .meas(meas), .freq_trip_flag(ftrip), .rate_trip_flag(rtrip),
		.measured_freq(mfreq), .freq_source(src));
	fpe_fe_model #(.PERIOD(8)) u_fe (.clk(clk), .rst_n(rst_n), .fv(fv), .fi(fi), .v1(v1),
		.i1(i1), .trk(trk), .meas(meas));

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	task automatic complete_run();
		$display("checks %0d failures %0d", n_checks, failures);
		if (failures == 0 && n_checks > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			failures++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
			output logic [31:0] r, output logic e);
		int k;
		@(posedge clk);
		psel    <= 1'b1;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= d;
		@(posedge clk);
		penable <= 1'b1;
		k = 0;
		do begin
			@(posedge clk);
			k++;
		end while (pready !== 1'b1 && k < 20);
		r = prdata;
		e = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
		if (k >= 20) begin
			failures++;
			complete_run();
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic xe);
		logic [31:0] r;
		logic        e;
		apb(1'b1, a, d, r, e);
		chk(e, xe);
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] x);
		logic [31:0] r;
		logic        e;
		apb(1'b0, a, 32'h0, r, e);
		chk(r, x);
		chk(e, 1'b0);
	endtask

	// returns at the edge where the design takes a strobe
	task automatic strobes(input int n);
		int k;
		repeat (n) begin
			k = 0;
			do begin
				@(posedge clk);
				k++;
			end while (meas.cycle_strobe !== 1'b1 && k < 40);
			if (k >= 40) begin
				failures++;
				complete_run();
			end
		end
	endtask

	task automatic settle(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask

	task automatic trip_time(input int i, input int lo, input int hi);
		int k;
		k = 0;
		do begin
			@(posedge clk);
			k++;
		end while (ftrip[i] !== 1'b1 && k < 100);
		chk(k >= lo && k <= hi, 1'b1);
		if (k >= 100) begin
			complete_run();
		end
	endtask

	// one frequency step per power cycle
	task automatic ramp(input int st, input int n);
		repeat (n) begin
			strobes(1);
			fv <= fv + st[15:0];
		end
	endtask

	// element 0 at 2.00 Hz/s (six cycle window), flat start then ramp
	task automatic rate_case(input logic [1:0] tr, input logic tk, input logic [15:0] vs,
			input logic [15:0] f0, input int st, input logic [3:0] x);
		wr(REG_RATE_BASE, {14'h0, tr, 16'h00C8}, 1'b0);
		wr(REG_SUPERV, {16'h0, vs}, 1'b0);
		strobes(1);
		fv  <= f0;
		trk <= tk;
		ramp(0, 10);
		chk(rtrip, 4'h0);
		ramp(st, 12);
		settle(3);
		chk(rtrip, x);
	endtask

	// ----------------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------------
	initial begin
		repeat (4) @(posedge clk);
		rst_n <= 1'b1;
		rd(REG_CONFIG, 32'h0001_1770);
		rd(REG_STATUS, 32'h1770_0000);
		rd(REG_FREQ_BASE, 32'h0064_0000);
		rd(REG_RATE_BASE, 32'h0002_0000);
		wr(8'hFC, 32'h1, 1'b1);
		wr(REG_STATUS, 32'h1, 1'b1);
		strobes(3);
		settle(3);
		chk(src, SRC_NOMINAL);
		chk(mfreq, 16'h1770);
		strobes(1);
		i1 <= 16'h0032;
		strobes(2);
		settle(3);
		chk(mfreq, 16'h1766);
		strobes(1);
		i1 <= 16'h0031;
		strobes(2);
		settle(3);
		chk(src, SRC_NOMINAL);
		strobes(1);
		i1 <= 16'h0032;
		v1 <= 16'h03E9;
		strobes(2);
		settle(3);
		chk(src, SRC_CURRENT);
		strobes(1);
		settle(3);
		chk(src, SRC_VOLTAGE);
		chk(mfreq, 16'h177A);
		wr(REG_FREQ_BASE, 32'h000A_173E, 1'b0);
		wr(8'h14, 32'h000A_17A2, 1'b0);
		wr(8'h1C, 32'h000A_07CF, 1'b0);
		rd(8'h1C, 32'h000A_0000);
		strobes(1);
		fv <= 16'h1734;
		strobes(2);
		trip_time(0, 28, 40);
		settle(3);
		chk(ftrip, 6'h01);
		strobes(1);
		fv <= 16'h1770;
		strobes(2);
		settle(3);
		chk(ftrip, 6'h00);
		strobes(1);
		fv <= 16'h1734;
		strobes(3);
		fv <= 16'h1770;
		strobes(1);
		fv <= 16'h1734;
		strobes(2);
		settle(30);
		chk(ftrip[0], 1'b0);
		trip_time(0, 1, 24);
		strobes(1);
		fv <= 16'h17AC;
		strobes(2);
		trip_time(1, 28, 40);
		settle(3);
		chk(ftrip, 6'h02);
		wr(REG_CONFIG, 32'h0003_1770, 1'b0);
		wr(8'h34, 32'h0002_0002, 1'b0);
		wr(8'h38, 32'h0002_00C8, 1'b0);
		wr(8'h3C, 32'h0002_0002, 1'b0);
		rate_case(2'h1, 1'b1, 16'h0, 16'h1770, -4, 4'h1);
		ramp(-4, 1);
		ramp(-3, 5);
		ramp(-4, 1);
		ramp(-3, 5);
		settle(3);
		chk(rtrip, 4'h1);
		ramp(-3, 8);
		settle(3);
		chk(rtrip, 4'h0);
		rate_case(2'h0, 1'b1, 16'h0, 16'h1770, -4, 4'h0);
		rate_case(2'h0, 1'b1, 16'h0, 16'h16A8, 4, 4'h0);
		rate_case(2'h2, 1'b1, 16'h0, 16'h1770, 4, 4'h1);
		rate_case(2'h1, 1'b0, 16'h0, 16'h1770, -4, 4'h0);
		rate_case(2'h1, 1'b1, 16'h07D0, 16'h1770, -4, 4'h0);
		rate_case(2'h1, 1'b1, 16'h0100, 16'h1770, -4, 4'h1);
		wr(REG_CONFIG, 32'h0005_1770, 1'b0);
		rate_case(2'h2, 1'b1, 16'h0, 16'h1770, 4, 4'h3);
		complete_run();
	end
endmodule
`default_nettype wire
